/* flash_access_cfg.svh */
// constants for the flash access and wait-state controller
`ifndef FLASH_ACCESS_CFG_SVH
`define FLASH_ACCESS_CFG_SVH
// ----------------------------------------
// reset values and the far-access extension value
// ----------------------------------------
`define WAIT_COUNT_RESET    4'h4
`define WAIT_EXT_RESET      2'h0
`define WAIT_EXT_FAR        2'h1
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ             125
`define ERASE_TIME_US       8000
`define PROGRAM_TIME_US     3500
`define ERASE_CYCLES        (`ERASE_TIME_US * `CLK_MHZ)
`define PROGRAM_CYCLES      (`PROGRAM_TIME_US * `CLK_MHZ)
`define CTRL_OVERHEAD       4
`endif

/* flash_access_pkg.sv */
// types for the flash access and wait-state controller
package flash_access_pkg;
	typedef enum logic [3:0] {
		RD_IDLE = 4'h1,
		RD_WAIT = 4'h2,
		RD_DONE = 4'h4,
		RD_HOLD = 4'h8
	} rd_state_t;
	typedef enum logic [1:0] {
		OP_NONE    = 2'h0,
		OP_ERASE   = 2'h1,
		OP_PROGRAM = 2'h2
	} op_kind_t;
endpackage

/* flash_access_waitstate_ctrl.sv */
// flash read wait-state, cache window and background erase/program control
// Function
// - any module may be modified while reads come from another module, never the one being read.
// - the data flash module accepts erase or program while reads come from any other module.
// - wait states apply to non-sequential reads outside the window and to cacheable-window misses; sequential reads outside the window are served by prefetch.
// - a cacheable-window read that misses takes one wait state beyond the normal count.
// - a cacheable-window read that hits completes with no wait state.
// - erasing a sector or page completes within 8.0 ms.
// - programming a page completes within 3.5 ms.
// - the control sequencer adds a few system clock cycles to each operation.
// - after delivery every sector reads erased with no protection active.
`timescale 1ns/10ps
`include "flash_access_cfg.svh"
module flash_access_waitstate_ctrl
	import flash_access_pkg::*;
#(
	parameter int MODULES        = 5,
	parameter int DATA_MODULE    = 4,
	parameter int DW             = 32,
	parameter int ERASE_CYCLES   = `ERASE_CYCLES,
	parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [3:0]   flash_wait_count,
	input  wire logic [1:0]   wait_extension_count,
	input  wire logic         startup_far_access_bit,
	input  wire logic         cfg_load,
	input  wire logic         rd_req,
	input  wire logic         rd_seq,
	input  wire logic         rd_cacheable,
	input  wire logic         rd_cache_hit,
	input  wire logic [2:0]   rd_module,
	input  wire logic [DW-1:0] array_rdata,
	input  wire logic         op_req,
	input  wire op_kind_t     op_kind,
	input  wire logic [2:0]   op_module,
	output logic              rd_ready,
	output logic [DW-1:0]     rd_data,
	output logic              op_accept,
	output logic              op_reject,
	output logic              op_busy,
	output logic              op_done,
	output logic [2:0]        op_active_module
);
	// ----------------------------------------
	// wait configuration
	// ----------------------------------------
	logic [3:0] wait_cnt_cfg;
	logic [1:0] wait_ext_cfg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_cnt_cfg <= `WAIT_COUNT_RESET;
			wait_ext_cfg <= `WAIT_EXT_RESET;
		end else if (cfg_load) begin
			wait_cnt_cfg <= flash_wait_count;
			wait_ext_cfg <= wait_extension_count;
		end else if (startup_far_access_bit && wait_ext_cfg == 2'h0) begin
			wait_ext_cfg <= `WAIT_EXT_FAR;
		end
	end
	// ----------------------------------------
	// read path
	// ----------------------------------------
	rd_state_t   rd_state;
	logic [5:0]  rd_cnt;
	logic [2:0]  rd_src;
	logic [5:0]  next_wait;
	always_comb begin
		if (rd_cacheable && rd_cache_hit)
			next_wait = 6'h00;
		else if (rd_seq && !rd_cacheable)
			next_wait = 6'h00;
		else
			next_wait = 6'({2'h0, wait_cnt_cfg} + {4'h0, wait_ext_cfg})
				+ 6'(rd_cacheable);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_state <= RD_IDLE;
			rd_cnt   <= 6'h00;
			rd_ready <= 1'b0;
			rd_data  <= '0;
			rd_src   <= 3'h7;
		end else begin
			rd_ready <= 1'b0;
			case (rd_state)
				RD_IDLE: begin
					if (rd_req) begin
						rd_src <= rd_module;
						rd_cnt <= next_wait;
						rd_state <= (next_wait == 6'h00) ? RD_DONE : RD_WAIT;
					end
				end
				RD_WAIT: begin
					rd_cnt <= rd_cnt - 6'h01;
					if (rd_cnt == 6'h01)
						rd_state <= RD_DONE;
				end
				RD_DONE: begin
					rd_ready <= 1'b1;
					rd_data  <= (op_busy && op_active_module == rd_src) ? '1 : array_rdata;
					rd_state <= RD_HOLD;
				end
				RD_HOLD: begin
					rd_src   <= 3'h7;
					rd_state <= RD_IDLE;
				end
				default: rd_state <= RD_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// background erase / program
	// ----------------------------------------
	logic [31:0] op_cnt;
	logic        op_allowed;
	always_comb begin
		if (op_module == 3'(DATA_MODULE))
			op_allowed = !(rd_req && rd_module == op_module) && rd_src != op_module;
		else
			op_allowed = !(rd_req && rd_module == op_module) && rd_src != op_module
				&& 32'(op_module) < 32'(MODULES);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			op_busy          <= 1'b0;
			op_accept        <= 1'b0;
			op_reject        <= 1'b0;
			op_done          <= 1'b0;
			op_cnt           <= 32'h0;
			op_active_module <= 3'h7;
		end else begin
			op_accept <= 1'b0;
			op_reject <= 1'b0;
			op_done   <= 1'b0;
			if (op_busy) begin
				op_cnt <= op_cnt - 32'h1;
				if (op_cnt == 32'h1) begin
					op_busy          <= 1'b0;
					op_done          <= 1'b1;
					op_active_module <= 3'h7;
				end
			end else if (op_req && op_kind != OP_NONE) begin
				if (op_allowed) begin
					op_busy          <= 1'b1;
					op_accept        <= 1'b1;
					op_active_module <= op_module;
					op_cnt <= (op_kind == OP_ERASE)
						? 32'(ERASE_CYCLES - `CTRL_OVERHEAD)
						: 32'(PROGRAM_CYCLES - `CTRL_OVERHEAD);
				end else begin
					op_reject <= 1'b1;
				end
			end
		end
	end
	// ----------------------------------------
	// operation length monitor
	// ----------------------------------------
	logic [31:0] busy_len;
	logic        busy_erase;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_len   <= 32'h0;
			busy_erase <= 1'b0;
		end else begin
			busy_len <= op_busy ? busy_len + 32'h1 : 32'h0;
			if (!op_busy && op_req && op_allowed)
				busy_erase <= (op_kind == OP_ERASE);
		end
	end
	// ----------------------------------------
	// read checks
	// ----------------------------------------
	ready_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_ready |=> !rd_ready)
		else $error("read ready held longer than one cycle");
	erased_read_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_state == RD_DONE && op_busy && op_active_module == rd_src |=> rd_data == '1)
		else $error("read of busy module did not return erased data");
	hit_no_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_state == RD_IDLE && rd_req && rd_cacheable && rd_cache_hit |-> ##2 rd_ready)
		else $error("cache hit did not return in two cycles");
	seq_no_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_state == RD_IDLE && rd_req && rd_seq && !rd_cacheable |-> ##2 rd_ready)
		else $error("sequential read stalled");
	miss_extra_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_state == RD_IDLE && rd_req && rd_cacheable && !rd_cache_hit
		|=> rd_cnt == 6'(wait_cnt_cfg + wait_ext_cfg + 1))
		else $error("cache miss wait count wrong");
	nonseq_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
		rd_state == RD_IDLE && rd_req && !rd_seq && !rd_cacheable
		|=> rd_cnt == 6'(wait_cnt_cfg + wait_ext_cfg))
		else $error("non-sequential wait count wrong");
	// ----------------------------------------
	// operation and far-access extension checks
	// ----------------------------------------
	read_clash_a: assert property (@(posedge clk) disable iff (!arst_n)
		!op_busy && op_req && op_kind != OP_NONE && rd_src == op_module |=> op_reject)
		else $error("operation on module being read not refused");
	range_reject_a: assert property (@(posedge clk) disable iff (!arst_n)
		!op_busy && op_req && op_kind != OP_NONE && 32'(op_module) >= 32'(MODULES)
		|=> op_reject)
		else $error("operation on missing module not refused");
	erase_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
		op_busy && busy_erase |-> busy_len < 32'(ERASE_CYCLES))
		else $error("erase exceeds its time limit");
	prog_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
		op_busy && !busy_erase |-> busy_len < 32'(PROGRAM_CYCLES))
		else $error("program exceeds its time limit");
	no_self_mod_a: assert property (@(posedge clk) disable iff (!arst_n)
		op_accept |-> op_active_module != rd_src)
		else $error("module modified while being read");
	data_mod_a: assert property (@(posedge clk) disable iff (!arst_n)
		!op_busy && op_req && op_kind != OP_NONE && op_module == 3'(DATA_MODULE)
		&& rd_module != op_module && rd_src != op_module |=> op_accept)
		else $error("data module operation refused");
	busy_done_a: assert property (@(posedge clk) disable iff (!arst_n)
		op_done |-> $past(op_busy) && !op_busy)
		else $error("done without a finished operation");
	far_ext_a: assert property (@(posedge clk) disable iff (!arst_n)
		startup_far_access_bit && !cfg_load && wait_ext_cfg == 2'h0 |=> wait_ext_cfg != 2'h0)
		else $error("far access did not raise extension");
endmodule

/* core_model.sv */
// processor core model issuing single flash reads
`timescale 1ns/10ps
module core_model (
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [5:0] kind,
	output logic            rd_req,
	output logic            rd_seq,
	output logic            rd_cacheable,
	output logic            rd_cache_hit,
	output logic [2:0]      rd_module,
	output logic [7:0]      lat
);
	// one-cycle request, then count cycles until the answer
	always @(posedge clk) begin
		rd_req <= start;
		if (start) begin
			{rd_seq, rd_cacheable, rd_cache_hit, rd_module} <= kind;
		end
		lat <= start ? 8'h00 : lat + 8'h01;
	end
endmodule

/* flash_access_waitstate_ctrl_tb_top.sv */
// testbench for the flash access and wait-state controller
`timescale 1ns/10ps
module flash_access_waitstate_ctrl_tb_top;
	import flash_access_pkg::*;
	logic        clk, arst_n, cfg_load, op_req, start, rd_req, rd_seq, rd_cacheable;
	logic        rd_cache_hit, rd_ready, op_accept, op_reject, op_busy, op_done, far_bit;
	logic [3:0]  wcnt;
	logic [1:0]  ecnt;
	logic [2:0]  rd_module, op_module, op_active_module;
	logic [31:0] rd_data;
	logic [5:0]  kind;
	logic [7:0]  lat;
	op_kind_t    op_kind;
	int          fail_count, cmp_count;
	localparam logic [31:0] D = 32'h5A5AC3C3;
	always #4 clk = ~clk;
	core_model i_core (.clk(clk), .start(start), .kind(kind), .rd_req(rd_req),
		.rd_seq(rd_seq), .rd_cacheable(rd_cacheable), .rd_cache_hit(rd_cache_hit),
		.rd_module(rd_module), .lat(lat));
	flash_access_waitstate_ctrl #(.ERASE_CYCLES(20), .PROGRAM_CYCLES(10)) i_dut (
		.clk(clk), .arst_n(arst_n), .flash_wait_count(wcnt), .wait_extension_count(ecnt),
		.startup_far_access_bit(far_bit), .cfg_load(cfg_load), .rd_req(rd_req),
		.rd_seq(rd_seq), .rd_cacheable(rd_cacheable), .rd_cache_hit(rd_cache_hit),
		.rd_module(rd_module), .array_rdata(D), .op_req(op_req), .op_kind(op_kind),
		.op_module(op_module), .rd_ready(rd_ready), .rd_data(rd_data),
		.op_accept(op_accept), .op_reject(op_reject), .op_busy(op_busy),
		.op_done(op_done), .op_active_module(op_active_module));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_go(input logic [5:0] k);
		@(posedge clk);
		start <= 1'b1;
		kind <= k;
		@(posedge clk);
		start <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] w, input logic [31:0] d);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (rd_ready !== 1'b1 && n < 40);
		if (rd_ready !== 1'b1) begin
			chk({31'h0, rd_ready}, 32'h1);
			stop_test();
		end
		chk({24'h0, lat}, {24'h0, w + 8'h02});
		chk(rd_data, d);
	endtask
	task automatic op_go(input op_kind_t k, input logic [2:0] m, input logic [2:0] exp);
		@(posedge clk);
		op_req <= 1'b1;
		op_kind <= k;
		op_module <= m;
		@(posedge clk);
		op_req <= 1'b0;
		#1;
		chk({29'h0, op_accept, op_reject, op_busy}, {29'h0, exp});
	endtask
	task automatic op_wait(input int n);
		int c;
		c = 0;
		while (op_done !== 1'b1 && c < n) begin
			@(posedge clk);
			#1;
			c++;
		end
		chk({31'h0, op_done}, 32'h1);
		if (op_done !== 1'b1)
			stop_test();
	endtask
	initial begin
		{clk, arst_n, cfg_load, op_req, start} = 5'h00;
		far_bit = 1'b1;
		{wcnt, ecnt, op_module, kind} = 15'h0000;
		op_kind = OP_NONE;
		{fail_count, cmp_count} = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk({28'h0, op_busy, op_active_module}, {28'h0, 1'b0, 3'h7});
		rd_go(6'h01);
		rd_chk(8'h05, D);
		@(posedge clk);
		wcnt <= 4'h6;
		ecnt <= 2'h1;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		rd_go(6'h02);
		rd_chk(8'h07, D);
		rd_go(6'h22);
		rd_chk(8'h00, D);
		rd_go(6'h12);
		rd_chk(8'h08, D);
		rd_go(6'h1A);
		rd_chk(8'h00, D);
		rd_go(6'h01);
		op_go(OP_ERASE, 3'h1, 3'h2);
		rd_chk(8'h07, D);
		op_go(OP_PROGRAM, 3'h5, 3'h2);
		op_go(OP_ERASE, 3'h4, 3'h5);
		rd_go(6'h24);
		rd_chk(8'h00, 32'hFFFFFFFF);
		op_wait(20);
		op_go(OP_PROGRAM, 3'h2, 3'h5);
		op_wait(10);
		stop_test();
	end
endmodule
